// *** include/kasd_cfg.svh ***
// constants of the kernel address segment decoder
`ifndef KASD_CFG_SVH
`define KASD_CFG_SVH

// *********************************
// address decode constants
// *********************************
`define KASD_PRIV_KERNEL 2'h0
`define KASD_TOP_USEG 1'h0
`define KASD_TOP3_DC 3'h4
`define KASD_TOP3_DU 3'h5
`define KASD_TOP3_SUPV 3'h6
`define KASD_TOP3_KERN 3'h7
`define KASD_REG_USER 2'h0
`define KASD_REG_SUPV 2'h1
`define KASD_REG_PHYS 2'h2
`define KASD_REG_KERN 2'h3
`define KASD_SEG0_BASE 32'h8000_0000
`define KASD_SEG1_BASE 32'hA000_0000
`define KASD_ATTR_UNCACHED 3'h2

// *********************************
// staging register numbers and masks
// *********************************
`define KASD_REG_LO0 5'h02
`define KASD_REG_LO1 5'h03
`define KASD_REG_PMASK 5'h05
`define KASD_REG_HI 5'h0a
`define KASD_HI_WMASK 64'hc000_00ff_ffff_f8ff
`define KASD_LO_WMASK 64'h0000_0000_0fff_ffff
`define KASD_PM_WMASK 64'h0000_0000_0007_f800
`define KASD_TLB_ENTRIES 32
`define KASD_STAGE_RESET 64'h0000_0000_0000_0000

`endif

// *** include/kasd_pkg.sv ***
// types of the kernel address segment decoder
package kasd_pkg;

    typedef enum logic [3:0] {
        kasd_seg_none = 4'h0,
        kasd_seg_user = 4'h1,
        kasd_seg_supv = 4'h2,
        kasd_seg_direct_cached = 4'h3,
        kasd_seg_direct_uncached = 4'h4,
        kasd_seg_translated_kernel = 4'h5,
        kasd_seg_phys_window = 4'h6,
        kasd_seg_error_user = 4'h7
    } kasd_seg_t;

    typedef struct packed {
        logic [1:0] privilege_level_field;
        logic exception_level_bit;
        logic error_level_bit;
        logic kernel_wide_addressing_bit;
        logic [2:0] unmapped_kernel_cache_field;
        logic [7:0] address_space_identifier;
    } kasd_mode_t;

    typedef struct packed {
        logic valid;
        logic kernel;
        kasd_seg_t seg;
        logic mapped;
        logic cached;
        logic addr_error;
        logic [31:0] phys;
        logic [7:0] space_id_tag;
    } kasd_result_t;

    typedef struct packed {
        logic [21:0] pfn;
        logic [2:0] attr;
        logic dirty;
        logic valid;
    } kasd_lo_t;

    typedef struct packed {
        logic [1:0] region;
        logic [28:0] paired_virtual_page_number;
        logic [7:0] space_id;
        logic [7:0] mask;
        logic global;
        kasd_lo_t even;
        kasd_lo_t odd;
    } kasd_entry_t;

endpackage : kasd_pkg

// *** hw/kasd_seg32.sv ***
// decode of one 512-Mbyte kernel segment from three address bits
`timescale 1ns/1ps
`include "kasd_cfg.svh"

module kasd_seg32 (
    input wire logic [2:0] top3,
    input wire logic [2:0] cache_field,
    output kasd_pkg::kasd_seg_t seg,
    output logic mapped,
    output logic cached
);

    always_comb begin
        case (top3)
            `KASD_TOP3_DC: begin
                seg = kasd_pkg::kasd_seg_direct_cached;
                mapped = 1'b0;
                cached = (cache_field != `KASD_ATTR_UNCACHED);
            end
            `KASD_TOP3_DU: begin
                seg = kasd_pkg::kasd_seg_direct_uncached;
                mapped = 1'b0;
                cached = 1'b0;
            end
            `KASD_TOP3_SUPV: begin
                seg = kasd_pkg::kasd_seg_supv;
                mapped = 1'b1;
                cached = 1'b0;
            end
            `KASD_TOP3_KERN: begin
                seg = kasd_pkg::kasd_seg_translated_kernel;
                mapped = 1'b1;
                cached = 1'b0;
            end
            default: begin
                seg = kasd_pkg::kasd_seg_user;
                mapped = 1'b1;
                cached = 1'b0;
            end
        endcase
    end

endmodule : kasd_seg32

// *** hw/kasd_entry_store.sv ***
// translation buffer entry array
`timescale 1ns/1ps
`include "kasd_cfg.svh"

module kasd_entry_store (
    input wire logic clock,
    input wire logic rst,
    input wire logic write_en,
    input wire logic [4:0] index,
    input wire kasd_pkg::kasd_entry_t write_entry,
    output kasd_pkg::kasd_entry_t read_entry
);

    kasd_pkg::kasd_entry_t entries [`KASD_TLB_ENTRIES];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `KASD_TLB_ENTRIES; i++) begin
                entries[i] <= '0;
            end
        end else if (write_en) begin
            entries[index] <= write_entry;
        end
    end

    assign read_entry = entries[index];

endmodule : kasd_entry_store

// *** hw/kasd_decoder.sv ***
// kernel address segment decoder with entry staging registers
// Notes on behaviour
// - kernel when privilege zero, exception or error
// - wide bit picks 32- or 64-bit map
// - 32-bit bit31 clear: mapped user, identifier appended
// - top 100: unmapped, physical is address minus 0x80000000
// - that segment caches per configuration cache field
// - top 101: unmapped uncached, minus 0xA0000000
// - top 110: mapped supervisor segment with identifier
// - top 111: mapped kernel segment with identifier
// - 64-bit 63:62=00: mapped user with identifier
// - error level makes 64-bit user region unmapped uncached
// - 64-bit 63:62=01: mapped supervisor with identifier
// - 63:62=10 physical window, 58:32 nonzero errors
// - bits 61:59 pick attribute, 2 uncached
// - 63:62=11 mapped kernel up to its limit
// - 61:31 all ones: bits 30:29 pick compat segment
// - compat segments mirror the four 32-bit ones
// - global bit in entry, reserved in high staging
// - entry holds paired virtual page number
// - address space identifier is eight bits
// - reserved staging bits written zero, read zero
`timescale 1ns/1ps
`include "kasd_cfg.svh"

module kasd_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic access_valid,
    input wire logic [63:0] virtual_address,
    input wire kasd_pkg::kasd_mode_t mode,
    input wire logic stage_write,
    input wire logic [4:0] stage_regnum,
    input wire logic [63:0] stage_wdata,
    input wire logic tlb_write,
    input wire logic tlb_read,
    input wire logic [4:0] tlb_index,
    output kasd_pkg::kasd_result_t result,
    output logic [63:0] stage_rdata
);

    // *********************************
    // privilege and segment decode
    // *********************************
    logic kernel;
    logic [63:0] va;
    kasd_pkg::kasd_seg_t s32_seg;
    logic s32_mapped;
    logic s32_cached;
    kasd_pkg::kasd_seg_t cmp_seg;
    logic cmp_mapped;
    logic cmp_cached;
    logic compat;
    kasd_pkg::kasd_result_t next_result;

    assign va = virtual_address;
    assign kernel = (mode.privilege_level_field == `KASD_PRIV_KERNEL)
        || mode.exception_level_bit || mode.error_level_bit;
    assign compat = (va[63:62] == `KASD_REG_KERN) && (&va[61:31]);

    kasd_seg32 u_seg32 (
        .top3(va[31:29]),
        .cache_field(mode.unmapped_kernel_cache_field),
        .seg(s32_seg),
        .mapped(s32_mapped),
        .cached(s32_cached)
    );

    // compat space reuses the 32-bit decode with bit 31 forced high
    kasd_seg32 u_compat (
        .top3({1'b1, va[30:29]}),
        .cache_field(mode.unmapped_kernel_cache_field),
        .seg(cmp_seg),
        .mapped(cmp_mapped),
        .cached(cmp_cached)
    );

    always_comb begin
        next_result = '0;
        next_result.valid = access_valid;
        next_result.kernel = kernel;
        next_result.seg = kasd_pkg::kasd_seg_none;
        next_result.space_id_tag = mode.address_space_identifier;
        if (access_valid && kernel) begin
            if (!mode.kernel_wide_addressing_bit) begin
                if (va[31] == `KASD_TOP_USEG) begin
                    next_result.seg = kasd_pkg::kasd_seg_user;
                    next_result.mapped = 1'b1;
                end else begin
                    next_result.seg = s32_seg;
                    next_result.mapped = s32_mapped;
                    next_result.cached = s32_cached;
                end
                if (s32_seg == kasd_pkg::kasd_seg_direct_cached) begin
                    next_result.phys = va[31:0] - `KASD_SEG0_BASE;
                end else if (s32_seg == kasd_pkg::kasd_seg_direct_uncached) begin
                    next_result.phys = va[31:0] - `KASD_SEG1_BASE;
                end
            end else begin
                case (va[63:62])
                    `KASD_REG_USER: begin
                        if (mode.error_level_bit) begin
                            next_result.seg = kasd_pkg::kasd_seg_error_user;
                            next_result.phys = va[31:0];
                            next_result.addr_error = (va[61:31] != '0);
                        end else begin
                            next_result.seg = kasd_pkg::kasd_seg_user;
                            next_result.mapped = 1'b1;
                            next_result.addr_error = (va[61:40] != '0);
                        end
                    end
                    `KASD_REG_SUPV: begin
                        next_result.seg = kasd_pkg::kasd_seg_supv;
                        next_result.mapped = 1'b1;
                        next_result.addr_error = (va[61:40] != '0);
                    end
                    `KASD_REG_PHYS: begin
                        next_result.seg = kasd_pkg::kasd_seg_phys_window;
                        next_result.addr_error = (va[58:32] != '0);
                        next_result.cached = (va[61:59] != `KASD_ATTR_UNCACHED);
                        next_result.phys = va[31:0];
                    end
                    default: begin
                        if (compat) begin
                            next_result.seg = cmp_seg;
                            next_result.mapped = cmp_mapped;
                            next_result.cached = cmp_cached;
                            if (cmp_seg == kasd_pkg::kasd_seg_direct_cached) begin
                                next_result.phys = va[31:0] - `KASD_SEG0_BASE;
                            end else if (cmp_seg == kasd_pkg::kasd_seg_direct_uncached) begin
                                next_result.phys = va[31:0] - `KASD_SEG1_BASE;
                            end
                        end else begin
                            next_result.seg = kasd_pkg::kasd_seg_translated_kernel;
                            next_result.mapped = 1'b1;
                            next_result.addr_error = (va[61:40] != '0) || (&va[39:31]);
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

    // *********************************
    // staging registers and entry array
    // *********************************
    logic [63:0] hi;
    logic [63:0] lo0;
    logic [63:0] lo1;
    logic [63:0] pmask;
    logic [63:0] next_hi;
    logic [63:0] next_lo0;
    logic [63:0] next_lo1;
    logic [63:0] next_pmask;
    logic [63:0] next_rdata;
    kasd_pkg::kasd_entry_t wentry;
    kasd_pkg::kasd_entry_t rentry;

    always_comb begin
        wentry.region = hi[63:62];
        wentry.paired_virtual_page_number = hi[39:11];
        wentry.space_id = hi[7:0];
        wentry.mask = pmask[18:11];
        wentry.global = lo0[0] & lo1[0];
        wentry.even = lo0[27:1];
        wentry.odd = lo1[27:1];
    end

    kasd_entry_store u_store (
        .clock(clock),
        .rst(rst),
        .write_en(tlb_write),
        .index(tlb_index),
        .write_entry(wentry),
        .read_entry(rentry)
    );

    always_comb begin
        next_hi = hi;
        next_lo0 = lo0;
        next_lo1 = lo1;
        next_pmask = pmask;
        if (tlb_read) begin
            next_hi = {rentry.region, 22'h0, rentry.paired_virtual_page_number,
                3'h0, rentry.space_id};
            next_lo0 = {36'h0, rentry.even, rentry.global};
            next_lo1 = {36'h0, rentry.odd, rentry.global};
            next_pmask = {45'h0, rentry.mask, 11'h0};
        end else if (stage_write) begin
            case (stage_regnum)
                `KASD_REG_HI: next_hi = stage_wdata & `KASD_HI_WMASK;
                `KASD_REG_LO0: next_lo0 = stage_wdata & `KASD_LO_WMASK;
                `KASD_REG_LO1: next_lo1 = stage_wdata & `KASD_LO_WMASK;
                `KASD_REG_PMASK: next_pmask = stage_wdata & `KASD_PM_WMASK;
                default: next_hi = hi;
            endcase
        end
        case (stage_regnum)
            `KASD_REG_HI: next_rdata = hi & `KASD_HI_WMASK;
            `KASD_REG_LO0: next_rdata = lo0 & `KASD_LO_WMASK;
            `KASD_REG_LO1: next_rdata = lo1 & `KASD_LO_WMASK;
            `KASD_REG_PMASK: next_rdata = pmask & `KASD_PM_WMASK;
            default: next_rdata = 64'h0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hi <= `KASD_STAGE_RESET;
            lo0 <= `KASD_STAGE_RESET;
            lo1 <= `KASD_STAGE_RESET;
            pmask <= `KASD_STAGE_RESET;
            stage_rdata <= `KASD_STAGE_RESET;
        end else begin
            hi <= next_hi;
            lo0 <= next_lo0;
            lo1 <= next_lo1;
            pmask <= next_pmask;
            stage_rdata <= next_rdata;
        end
    end

    // *********************************
    // checks
    // *********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_kernel_detect: assert property (access_valid |=> result.kernel ==
        ($past(mode.privilege_level_field) == 2'h0 || $past(mode.exception_level_bit)
        || $past(mode.error_level_bit))) else $error("kernel detect wrong");
    a_useg_map: assert property (access_valid && kernel
        && !mode.kernel_wide_addressing_bit && !va[31] |=> result.mapped
        && result.seg == kasd_pkg::kasd_seg_user
        && result.space_id_tag == $past(mode.address_space_identifier))
        else $error("user segment not mapped");
    a_seg0_phys: assert property (access_valid && kernel
        && !mode.kernel_wide_addressing_bit && va[31:29] == 3'h4
        |=> result.phys == $past(va[31:0]) - 32'h8000_0000 && !result.mapped)
        else $error("cached direct physical wrong");
    a_seg0_cache: assert property (access_valid && kernel
        && !mode.kernel_wide_addressing_bit && va[31:29] == 3'h4
        |=> result.cached == ($past(mode.unmapped_kernel_cache_field) != 3'h2))
        else $error("cached direct attribute wrong");
    a_seg1_uncached: assert property (access_valid && kernel
        && !mode.kernel_wide_addressing_bit && va[31:29] == 3'h5
        |=> !result.cached && result.phys == $past(va[31:0]) - 32'ha000_0000)
        else $error("uncached direct wrong");
    a_supv_map: assert property (access_valid && kernel
        && !mode.kernel_wide_addressing_bit && va[31:29] == 3'h6
        |=> result.mapped && result.seg == kasd_pkg::kasd_seg_supv)
        else $error("supervisor segment wrong");
    a_kern_map: assert property (access_valid && kernel
        && !mode.kernel_wide_addressing_bit && va[31:29] == 3'h7
        |=> result.mapped && result.seg == kasd_pkg::kasd_seg_translated_kernel)
        else $error("kernel segment wrong");
    a_err_user: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h0 && mode.error_level_bit
        |=> !result.mapped && !result.cached && result.phys == $past(va[31:0]))
        else $error("error level user region wrong");
    a_phys_err: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h2
        |=> result.addr_error == ($past(va[58:32]) != 27'h0))
        else $error("physical window error wrong");
    a_phys_attr: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h2
        |=> result.cached == ($past(va[61:59]) != 3'h2) && !result.mapped)
        else $error("physical window attribute wrong");
    a_compat_seg: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h3 && (&va[61:31])
        && va[30:29] == 2'h1 |=> result.seg == kasd_pkg::kasd_seg_direct_uncached
        && !result.cached) else $error("compat segment wrong");
    a_not_kernel: assert property (access_valid && !kernel
        |=> result.seg == kasd_pkg::kasd_seg_none && !result.mapped)
        else $error("decode outside kernel");
    a_stage_zero: assert property (stage_write && !tlb_read
        && stage_regnum == 5'h0a ##1 stage_regnum == 5'h0a
        |=> stage_rdata == ($past(stage_wdata, 2) & 64'hc000_00ff_ffff_f8ff))
        else $error("reserved staging bits read nonzero");
    a_user64_map: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h0 && !mode.error_level_bit
        |=> result.mapped && result.seg == kasd_pkg::kasd_seg_user
        && result.addr_error == ($past(va[61:0]) > 62'h00ff_ffff_ffff))
        else $error("wide user segment wrong");
    a_supv64_map: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h1
        |=> result.mapped && result.seg == kasd_pkg::kasd_seg_supv
        && result.addr_error == ($past(va[61:0]) > 62'h00ff_ffff_ffff))
        else $error("wide supervisor segment wrong");
    a_xkseg_map: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h3 && !(&va[61:31])
        |=> result.mapped && result.seg == kasd_pkg::kasd_seg_translated_kernel
        && result.addr_error == ($past(va[61:0]) > 62'h00ff_7fff_ffff))
        else $error("wide kernel segment wrong");
    a_compat_dc: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h3 && (&va[61:31])
        && va[30:29] == 2'h0 |=> !result.mapped
        && result.seg == kasd_pkg::kasd_seg_direct_cached
        && result.cached == ($past(mode.unmapped_kernel_cache_field) != 3'h2)
        && result.phys == $past(va[31:0]) - 32'h8000_0000)
        else $error("compat cached segment wrong");
    a_compat_upper: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h3 && (&va[61:31])
        && va[30] |=> result.mapped && !result.addr_error
        && result.seg == ($past(va[29]) ? kasd_pkg::kasd_seg_translated_kernel
        : kasd_pkg::kasd_seg_supv)) else $error("compat mapped segment wrong");
    a_space_id: assert property (access_valid
        |=> result.space_id_tag == $past(mode.address_space_identifier))
        else $error("identifier not carried");
    a_idle_invalid: assert property (!access_valid
        |=> !result.valid && result.seg == kasd_pkg::kasd_seg_none)
        else $error("result valid without access");
    a_err_user_range: assert property (access_valid && kernel
        && mode.kernel_wide_addressing_bit && va[63:62] == 2'h0 && mode.error_level_bit
        |=> result.seg == kasd_pkg::kasd_seg_error_user
        && result.addr_error == ($past(va[61:0]) > 62'h7fff_ffff))
        else $error("error level range wrong");

endmodule : kasd_decoder

// *** sim/kasd_core_model.sv ***
// model of the core address source feeding the decoder
`timescale 1ns/1ps

module kasd_core_model (
    input wire logic clock,
    input wire logic cmd_valid,
    input wire logic [63:0] cmd_va,
    input wire kasd_pkg::kasd_mode_t cmd_mode,
    output logic access_valid,
    output logic [63:0] virtual_address,
    output kasd_pkg::kasd_mode_t mode
);
    logic [63:0] last_va = 64'h0;

    // idle cycles show the inverted last address so a stale value cannot match
    always @(posedge clock) begin
        if (cmd_valid) begin
            last_va <= cmd_va;
        end
    end

    assign access_valid = cmd_valid;
    assign virtual_address = cmd_valid ? cmd_va : ~last_va;
    assign mode = cmd_mode;
endmodule : kasd_core_model

// *** sim/tb_top.sv ***
// self-checking bench of the kernel address segment decoder
`timescale 1ns/1ps
`include "kasd_cfg.svh"

module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [63:0] cmd_va = 64'h0;
    kasd_pkg::kasd_mode_t cmd_mode = '0;
    logic access_valid;
    logic [63:0] virtual_address;
    kasd_pkg::kasd_mode_t mode;
    logic stage_write = 1'b0;
    logic [4:0] stage_regnum = 5'h00;
    logic [63:0] stage_wdata = 64'h0;
    logic tlb_write = 1'b0;
    logic tlb_read = 1'b0;
    logic [4:0] tlb_index = 5'h00;
    kasd_pkg::kasd_result_t result;
    logic [63:0] stage_rdata;
    logic [2:0] cache_fld = 3'h3;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;

    kasd_core_model core (
        .clock(clock),
        .cmd_valid(cmd_valid),
        .cmd_va(cmd_va),
        .cmd_mode(cmd_mode),
        .access_valid(access_valid),
        .virtual_address(virtual_address),
        .mode(mode)
    );

    kasd_decoder dut (
        .clock(clock),
        .rst(rst),
        .access_valid(access_valid),
        .virtual_address(virtual_address),
        .mode(mode),
        .stage_write(stage_write),
        .stage_regnum(stage_regnum),
        .stage_wdata(stage_wdata),
        .tlb_write(tlb_write),
        .tlb_read(tlb_read),
        .tlb_index(tlb_index),
        .result(result),
        .stage_rdata(stage_rdata)
    );

    // ******************************
    // clock and watchdog
    // ******************************
    initial begin
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            error_cnt++;
            $display("Error at %0t: cycle limit %h reached %h", $time, cycles, 5000);
            complete_run();
        end
    end

    // ******************************
    // tasks
    // ******************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // md is {privilege, exception, error, wide}; ex is {kernel, seg, mapped, cached, error}
    task automatic acc(input logic [4:0] md, input logic [63:0] va, input logic [7:0] ex,
                       input logic [31:0] ph);
        cmd_valid = 1'b1;
        cmd_va = va;
        cmd_mode = {md, cache_fld, 8'h5a};
        @(negedge clock);
        chk({55'h0, result.valid, result.kernel, result.seg, result.mapped, result.cached,
             result.addr_error}, {55'h0, 1'b1, ex});
        if (ex[2]) begin
            chk({56'h0, result.space_id_tag}, 64'h5a);
        end else if (ex[7]) begin
            chk({32'h0, result.phys}, {32'h0, ph});
        end
    endtask : acc

    task automatic idle();
        cmd_valid = 1'b0;
        @(negedge clock);
        chk({63'h0, result.valid}, 64'h0);
    endtask : idle

    task automatic st_wr(input logic [4:0] rn, input logic [63:0] d);
        stage_write = 1'b1;
        stage_regnum = rn;
        stage_wdata = d;
        @(negedge clock);
        stage_write = 1'b0;
        @(negedge clock);
    endtask : st_wr

    task automatic st_rd(input logic [4:0] rn, input logic [63:0] exp);
        stage_regnum = rn;
        repeat (2) @(negedge clock);
        chk(stage_rdata, exp);
    endtask : st_rd

    task automatic tlb_op(input logic wr, input logic [4:0] idx);
        tlb_write = wr;
        tlb_read = !wr;
        tlb_index = idx;
        @(negedge clock);
        tlb_write = 1'b0;
        tlb_read = 1'b0;
        @(negedge clock);
    endtask : tlb_op

    // ******************************
    // main sequence
    // ******************************
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        chk(64'(result), 64'h0);
        chk(stage_rdata, 64'h0);
        // back to back 32-bit decode
        acc(5'h00, 64'h0000_1234, 8'h8c, 32'h0);
        acc(5'h00, 64'h8000_1000, 8'h9a, 32'h0000_1000);
        acc(5'h00, 64'ha000_2000, 8'ha0, 32'h0000_2000);
        acc(5'h00, 64'hc000_0000, 8'h94, 32'h0);
        acc(5'h00, 64'hffff_ffff, 8'hac, 32'h0);
        cache_fld = 3'h2;
        acc(5'h00, 64'h8000_0000, 8'h98, 32'h0);
        idle();
        $display("decode32 test done");
        cache_fld = 3'h3;
        acc(5'h01, 64'h0000_0012_0000_0000, 8'h8c, 32'h0);
        acc(5'h03, 64'h0000_0000_0000_0040, 8'hb8, 32'h0000_0040);
        acc(5'h01, 64'h4000_0000_0000_1000, 8'h94, 32'h0);
        acc(5'h01, 64'h9000_0001_0000_0000, 8'hb1, 32'h0);
        for (int a = 0; a < 8; a++) begin
            acc(5'h01, {2'h2, a[2:0], 27'h0, 32'h1234_5678}, (a == 2) ? 8'hb0 : 8'hb2,
                32'h1234_5678);
        end
        acc(5'h01, 64'hc000_0000_0000_0000, 8'hac, 32'h0);
        acc(5'h01, 64'hc000_00ff_8000_0000, 8'had, 32'h0);
        acc(5'h01, 64'h0000_0100_0000_0000, 8'h8d, 32'h0);
        acc(5'h01, 64'h4000_0100_0000_0000, 8'h95, 32'h0);
        acc(5'h03, 64'h0000_0000_8000_0000, 8'hb9, 32'h8000_0000);
        acc(5'h01, 64'hffff_ffff_8000_0010, 8'h9a, 32'h0000_0010);
        acc(5'h01, 64'hffff_ffff_a000_0010, 8'ha0, 32'h0000_0010);
        acc(5'h01, 64'hffff_ffff_c000_0000, 8'h94, 32'h0);
        acc(5'h01, 64'hffff_ffff_e000_0000, 8'hac, 32'h0);
        idle();
        $display("decode64 test done");
        acc(5'h08, 64'h0000_1234, 8'h00, 32'h0);
        acc(5'h0c, 64'h0000_1234, 8'h8c, 32'h0);
        acc(5'h12, 64'ha000_0004, 8'ha0, 32'h0000_0004);
        idle();
        $display("privilege test done");
        st_wr(`KASD_REG_HI, `KASD_HI_WMASK);
        st_rd(`KASD_REG_HI, `KASD_HI_WMASK);
        st_wr(`KASD_REG_LO0, `KASD_LO_WMASK);
        st_rd(`KASD_REG_LO0, `KASD_LO_WMASK);
        st_wr(`KASD_REG_PMASK, `KASD_PM_WMASK);
        st_rd(`KASD_REG_PMASK, `KASD_PM_WMASK);
        st_wr(5'h07, '1);
        st_rd(5'h07, 64'h0);
        $display("staging test done");
        st_wr(`KASD_REG_HI, 64'hc000_0012_3456_785a);
        st_wr(`KASD_REG_LO0, 64'h0abc_def7);
        st_wr(`KASD_REG_LO1, 64'h0123_4564);
        st_wr(`KASD_REG_PMASK, 64'h0001_f800);
        tlb_op(1'b1, 5'h03);
        st_wr(`KASD_REG_HI, 64'h4000_0001_0000_0811);
        st_wr(`KASD_REG_LO0, 64'h0000_0001);
        st_wr(`KASD_REG_LO1, 64'h0000_0001);
        tlb_op(1'b1, 5'h1f);
        tlb_op(1'b0, 5'h03);
        st_rd(`KASD_REG_HI, 64'hc000_0012_3456_785a);
        st_rd(`KASD_REG_LO0, 64'h0abc_def6);
        st_rd(`KASD_REG_LO1, 64'h0123_4564);
        st_rd(`KASD_REG_PMASK, 64'h0001_f800);
        tlb_op(1'b0, 5'h1f);
        st_rd(`KASD_REG_HI, 64'h4000_0001_0000_0811);
        st_rd(`KASD_REG_LO1, 64'h0000_0001);
        tlb_op(1'b0, 5'h07);
        st_rd(`KASD_REG_HI, 64'h0);
        $display("entry test done");
        // mid-run reset must clear every entry, not only the staging registers
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        chk(64'(result), 64'h0);
        tlb_op(1'b0, 5'h03);
        st_rd(`KASD_REG_HI, 64'h0);
        $display("reset test done");
        complete_run();
    end
endmodule : tb_top
